// *** design/dual_baud_rate_divider.sv ***
// Purpose: Two independent baud clock dividers fed by one reference input
// Assumes: clk well above the reference rate; resetn pin is an async active-low reset
// Notes:   Reference, strobes and codes are asynchronous pins
// What this block does
// RULE1: 16X codes 0-7 divide 6144 down to 256
// RULE2: 16X codes 8-15 divide 171 down to 16
// RULE3: 32X codes 0-7 divide 3168 down to 264
// RULE4: 32X codes 8-15 divide 132 down to 8
// RULE5: Even divisors symmetric, odd within ten percent
// RULE6: Count reference rising edges, not levels
// RULE7: 32X output is thirty-two times baud
// RULE8: 32X set assumes 5.0688 MHz, out=ref/div
// RULE9: Strobe high loads rate code per direction
// RULE10: New frequency within six reference cycles
// RULE11: 16X set assumes 4.9152 MHz reference
// RULE12: Directions run independently from shared reference
`timescale 1ns/1ps
`include "baud_map.svh"

module dual_baud_rate_divider
    import baud_pkg::*;
#(
    parameter bit USE_32X = 1'b0        // Selects the 32X divisor set
)(
    input  wire logic      clk,             // 250 MHz system clock
    input  wire logic      resetn,          // Async reset, active low
    input  wire logic      reference_input, // Reference pin, edge counted
    input  wire rate_pin_s rx_pins,         // rx_code_latch and rx_rate_code
    input  wire rate_pin_s tx_pins,         // tx_code_latch and tx_rate_code
    output logic           rx_rate_clock,   // Receive baud clock
    output logic           tx_rate_clock    // Transmit baud clock
);

    // Table lookup; 32X set gives ref/div = 32 x baud [RULE7] [RULE8] [RULE11]
    function automatic div_t divisor(input rate_code_t code);
        logic [207:0] tbl;
        tbl = USE_32X ? `DIV32_TABLE : `DIV16_TABLE; // [RULE1] [RULE2] [RULE3] [RULE4]
        return tbl[(4'hf - code) * 13 +: 13];
    endfunction : divisor

    // High for the first ceil(div/2) edges; odd worst case 9/17 stays in band
    function automatic logic high_phase(input logic [12:0] cnt, input div_t div);
        div_t half;
        half = (div + 13'd1) >> 1;
        return cnt < half; // [RULE5]
    endfunction : high_phase

    // Reference pin: three flops, change accepted when stages two and three agree
    logic [`SYNC_STAGES-1:0] ref_s_r;
    logic [`SYNC_STAGES-1:0] ref_s_nxt;
    logic                    ref_lvl_r;
    logic                    ref_lvl_nxt;
    logic                    ref_edge;

    always_comb
    begin
        ref_s_nxt   = {ref_s_r[1:0], reference_input};
        ref_lvl_nxt = (ref_s_r[1] == ref_s_r[2]) ? ref_s_r[2] : ref_lvl_r;
    end

    // Rising edge only; the pin is sampled as a plain logic level by the flops
    assign ref_edge = (ref_s_r[1] == ref_s_r[2]) && ref_s_r[2] && !ref_lvl_r; // [RULE6]

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ref_s_r   <= '0;
            ref_lvl_r <= 1'b0;
        end
        else
        begin
            ref_s_r   <= ref_s_nxt;
            ref_lvl_r <= ref_lvl_nxt;
        end
    end

    // Per-direction state, index by dir_e
    rate_pin_s   pins       [2];
    rate_pin_s   psync_r    [2][`SYNC_STAGES];
    rate_pin_s   psync_nxt  [2][`SYNC_STAGES];
    rate_code_t  code_r     [2];
    rate_code_t  code_nxt   [2];
    rate_code_t  used_r     [2];
    rate_code_t  used_nxt   [2];
    logic [12:0] cnt_r      [2];
    logic [12:0] cnt_nxt    [2];
    logic        out_r      [2];
    logic        out_nxt    [2];
    logic        pend_r     [2];
    logic        pend_nxt   [2];
    div_t        div        [2];
    logic        pin_stable [2];

    assign pins[DIR_RX] = rx_pins;
    assign pins[DIR_TX] = tx_pins;

    always_comb
    begin
        for (int d = 0; d < 2; d++)
        begin
            psync_nxt[d][0] = pins[d];
            psync_nxt[d][1] = psync_r[d][0];
            psync_nxt[d][2] = psync_r[d][1];
            pin_stable[d]   = (psync_r[d][1] == psync_r[d][2]);
            div[d]          = divisor(used_r[d]);
            // Level-sensitive load; a tied-high strobe simply tracks the code
            code_nxt[d] = (pin_stable[d] && psync_r[d][2].code_latch)
                        ? psync_r[d][2].rate_code : code_r[d]; // [RULE9]
            used_nxt[d] = used_r[d];
            cnt_nxt[d]  = cnt_r[d];
            pend_nxt[d] = pend_r[d] || (code_r[d] != used_r[d]);
            if (ref_edge)
            begin
                pend_nxt[d] = 1'b0;
                used_nxt[d] = code_r[d];
                // Restart on a code change at the next edge, well inside the limit
                if (code_r[d] != used_r[d])
                    cnt_nxt[d] = `CNT_RESET; // [RULE10]
                else if (cnt_r[d] >= div[d] - 13'd1)
                    cnt_nxt[d] = `CNT_RESET;
                else
                    cnt_nxt[d] = cnt_r[d] + 13'd1;
            end
            // Each direction sees only its own code; shared edge only [RULE12]
            out_nxt[d] = high_phase(cnt_nxt[d], divisor(used_nxt[d]));
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int d = 0; d < 2; d++)
            begin
                for (int s = 0; s < `SYNC_STAGES; s++)
                    psync_r[d][s] <= '0;
                code_r[d] <= `CODE_RESET;
                used_r[d] <= `CODE_RESET;
                cnt_r[d]  <= `CNT_RESET;
                out_r[d]  <= 1'b0;
                pend_r[d] <= 1'b0;
            end
        end
        else
        begin
            psync_r <= psync_nxt;
            code_r  <= code_nxt;
            used_r  <= used_nxt;
            cnt_r   <= cnt_nxt;
            out_r   <= out_nxt;
            pend_r  <= pend_nxt;
        end
    end

    assign rx_rate_clock = out_r[DIR_RX];
    assign tx_rate_clock = out_r[DIR_TX];

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_load(int d);
        pin_stable[d] && psync_r[d][2].code_latch;
    endsequence

    sequence s_code_change(int d);
        ref_edge && (code_r[d] != used_r[d]);
    endsequence

    AST_RX_LOAD: assert property (s_load(0) // [RULE9]
                                  |=> code_r[0] == $past(psync_r[0][2].rate_code))
        else $error("rx code not loaded while strobe high");
    AST_TX_LOAD: assert property (s_load(1) // [RULE9]
                                  |=> code_r[1] == $past(psync_r[1][2].rate_code))
        else $error("tx code not loaded while strobe high");
    AST_TX_HOLD: assert property (!psync_r[1][2].code_latch // [RULE9]
                                  && !psync_r[1][1].code_latch
                                  |=> $stable(code_r[1]))
        else $error("tx code changed with strobe low");
    AST_RX_HOLD: assert property (!psync_r[0][2].code_latch // [RULE9]
                                  && !psync_r[0][1].code_latch
                                  |=> $stable(code_r[0]))
        else $error("rx code changed with strobe low");

    // Table corners; the bench runs one instance per divisor set
    AST_DIV_FIRST: assert property (used_r[0] == 4'h0 // [RULE1] [RULE3]
                                    |-> div[0] == (USE_32X ? 13'd3168 : 13'd6144))
        else $error("code 0 divisor wrong");
    AST_DIV_LAST: assert property (used_r[1] == 4'hf // [RULE2] [RULE4]
                                   |-> div[1] == (USE_32X ? 13'd8 : 13'd16))
        else $error("code 15 divisor wrong");
    AST_DIV_MID: assert property (used_r[0] == 4'h8 // [RULE2] [RULE4]
                                  |-> div[0] == (USE_32X ? 13'd132 : 13'd171))
        else $error("code 8 divisor wrong");
    AST_DIV_ODD: assert property (used_r[1] == 4'he // [RULE2] [RULE4]
                                  |-> div[1] == (USE_32X ? 13'd17 : 13'd32))
        else $error("code 14 divisor wrong");
    AST_WRAP: assert property (ref_edge && code_r[0] == used_r[0] // [RULE5]
                               && cnt_r[0] == div[0] - 13'd1
                               |=> cnt_r[0] == 13'h0000 && out_r[0])
        else $error("rx divider did not wrap at divisor");
    AST_FALL: assert property (ref_edge && code_r[1] == used_r[1] // [RULE5]
                               && cnt_r[1] == ((div[1] + 13'd1) >> 1) - 13'd1
                               |=> !out_r[1])
        else $error("tx clock did not fall at half period");
    AST_EDGE_ONLY: assert property (!ref_edge // [RULE6]
                                    |=> $stable(cnt_r[0]) && $stable(cnt_r[1]))
        else $error("divider moved without a reference edge");
    // A held high reference must count once, not every cycle
    AST_EDGE_PULSE: assert property (ref_edge |=> !ref_edge) // [RULE6]
        else $error("reference edge lasted more than one cycle");
    AST_SWITCH: assert property (s_code_change(0) // [RULE10]
                                 |=> cnt_r[0] == 13'h0000 && !pend_r[0])
        else $error("rx did not restart on new code");
    AST_TX_SWITCH: assert property (s_code_change(1) // [RULE10]
                                    |=> cnt_r[1] == 13'h0000 && !pend_r[1])
        else $error("tx did not restart on new code");
    AST_INDEP: assert property (s_code_change(0) && code_r[1] == used_r[1] // [RULE12]
                                && cnt_r[1] < div[1] - 13'd1
                                |=> cnt_r[1] == $past(cnt_r[1]) + 13'd1)
        else $error("tx disturbed by rx code change");
    AST_RX_INDEP: assert property (s_code_change(1) && code_r[0] == used_r[0] // [RULE12]
                                   && cnt_r[0] < div[0] - 13'd1
                                   |=> cnt_r[0] == $past(cnt_r[0]) + 13'd1)
        else $error("rx disturbed by tx code change");

endmodule : dual_baud_rate_divider

// *** design/baud_map.svh ***
// Purpose: Constants for the dual baud rate divider
// Assumes: Included by its bare name
// Notes:   Divisor tables are packed with code 0 in the top slot
`ifndef BAUD_MAP_SVH
`define BAUD_MAP_SVH

`define SYNC_STAGES   3
`define CODE_RESET    4'h0
`define CNT_RESET     13'h0000
// Reference frequencies in kHz that each divisor set is built for
`define REF16_KHZ     4915.2
`define REF32_KHZ     5068.8
`define OVERSAMPLE16  16
`define OVERSAMPLE32  32
`define SWITCH_MAX_REF_CYCLES 6
`define DIV16_TABLE {13'd6144, 13'd4096, 13'd2793, 13'd2284, 13'd2048, 13'd1024, \
                     13'd512, 13'd256, 13'd171, 13'd154, 13'd128, 13'd85, \
                     13'd64, 13'd43, 13'd32, 13'd16}
`define DIV32_TABLE {13'd3168, 13'd2112, 13'd1440, 13'd1178, 13'd1056, 13'd792, \
                     13'd528, 13'd264, 13'd132, 13'd88, 13'd66, 13'd44, \
                     13'd33, 13'd22, 13'd17, 13'd8}

`endif

// *** design/baud_pkg.sv ***
// Purpose: Types for the dual baud rate divider
// Assumes: Nothing beyond the map header
// Notes:   Direction index 0 is receive, 1 is transmit
package baud_pkg;
    typedef logic [3:0]  rate_code_t;
    typedef logic [12:0] div_t;

    typedef struct packed {
        logic       code_latch;
        rate_code_t rate_code;
    } rate_pin_s;

    typedef enum logic {DIR_RX, DIR_TX} dir_e;
endpackage : baud_pkg

// *** sim/rate_host.sv ***
// Purpose: Host model for rate codes, strobes and the reference
// Assumes: clk at 250 MHz; reference runs at clk/6
// Notes:   Code pins wander while strobes are low
`timescale 1ns/1ps
module rate_host
    import baud_pkg::*;
(
    input  wire logic clk,             // Bench clock
    output logic      reference_input, // 3 clk high, 3 low
    output rate_pin_s rx_pins,         // Receive strobe and code
    output rate_pin_s tx_pins          // Transmit strobe and code
);
    int seed = 32'h363a;
    int ph   = 0;
    bit busy = 1'b0;
    initial
    begin
        rx_pins = '0;
        tx_pins = '0;
        reference_input = 1'b0;
    end
    always @(posedge clk)
    begin
        ph <= (ph + 1) % 6;
        reference_input <= (ph < 3);
        // Noise on idle codes must be ignored by the device
        if (!busy)
        begin
            rx_pins.rate_code <= 4'($random(seed));
            tx_pins.rate_code <= 4'($random(seed));
        end
    end
    task automatic load(input dir_e d, input rate_code_t c);
        @(negedge clk) busy = 1'b1;
        @(posedge clk);
        if (d == DIR_RX) rx_pins.rate_code <= c;
        else tx_pins.rate_code <= c;
        repeat (4) @(posedge clk);
        if (d == DIR_RX) rx_pins.code_latch <= 1'b1;
        else tx_pins.code_latch <= 1'b1;
        repeat (4) @(posedge clk);
        rx_pins.code_latch <= 1'b0;
        tx_pins.code_latch <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk) busy = 1'b0;
    endtask : load
endmodule : rate_host

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the divider, both divisor sets
// Assumes: Reference is clk/6, so one ref edge is 6 clk
// Notes:   Driver queues expected timings, monitor measures them
`timescale 1ns/1ps
module tb;
    import baud_pkg::*;
    typedef struct {dir_e d; int per; int hi;} note_s;
    logic      clk = 1'b0;
    logic      resetn = 1'b0;
    logic      reference_input;
    rate_pin_s rx_pins;
    rate_pin_s tx_pins;
    logic      rx_rate_clock;
    logic      tx_rate_clock;
    logic      rx16_rate_clock;
    logic      tx16_rate_clock;
    int        err_count = 0;
    int        tests_run = 0;
    note_s     notes[$];
    note_s     notes16[$];
    // Code 0 last: its long period would stretch every later check
    int        cd[10] = '{15, 14, 13, 12, 11, 10, 9, 15, 8, 0};
    int        dv[10] = '{8, 17, 22, 33, 44, 66, 88, 8, 132, 3168};
    int        dv16[10] = '{16, 32, 43, 64, 85, 128, 154, 16, 171, 6144};
    always #2 clk = ~clk;
    rate_host i_host (.clk(clk), .reference_input(reference_input),
                      .rx_pins(rx_pins), .tx_pins(tx_pins));
    dual_baud_rate_divider #(.USE_32X(1'b1)) i_dut (
        .clk(clk), .resetn(resetn), .reference_input(reference_input),
        .rx_pins(rx_pins), .tx_pins(tx_pins),
        .rx_rate_clock(rx_rate_clock), .tx_rate_clock(tx_rate_clock));
    dual_baud_rate_divider #(.USE_32X(1'b0)) i_dut16 (
        .clk(clk), .resetn(resetn), .reference_input(reference_input),
        .rx_pins(rx_pins), .tx_pins(tx_pins),
        .rx_rate_clock(rx16_rate_clock), .tx_rate_clock(tx16_rate_clock));
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s %0d not %0d", $time, m, seen, exp);
        end
    endtask : check
    function automatic logic pick(input bit s16, input dir_e d);
        if (s16)
            return (d == DIR_RX) ? rx16_rate_clock : tx16_rate_clock;
        return (d == DIR_RX) ? rx_rate_clock : tx_rate_clock;
    endfunction : pick
    task automatic wait_lvl(input bit s16, input dir_e d, input logic v, output int n);
        n = 0;
        while (pick(s16, d) !== v && n < 40000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 40000)
        begin
            err_count++;
            $display("wrong value at %0t: output stuck", $time);
            conclude();
        end
    endtask : wait_lvl
    // One watcher per divisor set, so both instances are timed in parallel
    task automatic watch(input bit s16, ref note_s q[$]);
        note_s e;
        int    a;
        int    h;
        int    l;
        forever
        begin
            while (q.size() == 0) @(posedge clk);
            e = q[0];
            wait_lvl(s16, e.d, 1'b0, a);
            wait_lvl(s16, e.d, 1'b1, a);
            wait_lvl(s16, e.d, 1'b0, h);
            wait_lvl(s16, e.d, 1'b1, l);
            check(h, e.hi, "high time");
            check(h + l, e.per, "period");
            void'(q.pop_front());
        end
    endtask : watch
    // Reference edge every 6 clk; high for ceil(div/2) edges
    task automatic push(input dir_e d, input int k);
        notes.push_back('{d, 6 * dv[k], 6 * ((dv[k] + 1) / 2)});
        notes16.push_back('{d, 6 * dv16[k], 6 * ((dv16[k] + 1) / 2)});
    endtask : push
    initial watch(1'b0, notes);
    initial watch(1'b1, notes16);
    initial
    begin
        int   last[2];
        int   n;
        dir_e d;
        last = '{-1, -1};
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        for (int k = 0; k < 10; k++)
        begin
            d = dir_e'(k % 2);
            i_host.load(d, rate_code_t'(cd[k]));
            last[d] = k;
            push(d, k);
            // Other direction must keep its period across this load
            if (last[!d] >= 0) push(dir_e'(!d), last[!d]);
            n = 0;
            while ((notes.size() > 0 || notes16.size() > 0) && n < 90000)
            begin
                @(posedge clk);
                n++;
            end
            if (n >= 90000)
            begin
                check(1, 0, "queue not drained");
                conclude();
            end
        end
        conclude();
    end
endmodule : tb
